// ---- rtl/acf_cfg.svh ----
// Constants for the input configuration decode and output code formatting
`ifndef ACF_CFG_SVH
`define ACF_CFG_SVH

// Configuration word layout
`define ACF_CFG_W        14
`define ACF_CFG_RST      14'h3fff
`define ACF_INCC_HI      12
`define ACF_INCC_LO      10
`define ACF_CH_HI        9
`define ACF_CH_LO        7
`define ACF_BW_BIT       6

// Input configuration field codes
`define ACF_INCC_SE      3'h7
`define ACF_INCC_COM_UNI 3'h6
`define ACF_INCC_COM_BI  3'h2
`define ACF_INCC_RSVD    3'h3
`define ACF_PAIR_BIT     1
`define ACF_UNI_BIT      2
`define ACF_CH_PAIR_MASK 3'h1

// Raw difference from the converter core, in LSB steps
`define ACF_DIFF_W       18
`define ACF_UNI_MAX      18'sh0ffff
`define ACF_UNI_MIN      18'sh00000
`define ACF_BI_MAX       18'sh07fff
`define ACF_BI_MIN       18'sh38000
`define ACF_UNI_MID_IN   18'sh08000
`define ACF_ZERO_IN      18'sh00000

// Output codes
`define ACF_CODE_W       16
`define ACF_UNI_TOP      16'hffff
`define ACF_UNI_BOT      16'h0000
`define ACF_UNI_MID      16'h8000
`define ACF_BI_TOP       16'h7fff
`define ACF_BI_UNDER     16'hffff
`define ACF_BI_ZERO      16'h0000
`define ACF_BI_BOT       16'h8000

// Throughput timing
`define ACF_CLK_NS       25
`define ACF_CONV_NS      2000
`define ACF_BW_DIV       4
`define ACF_GAP_W        10

`endif

// ---- rtl/acf_pkg.sv ----
// Types shared by the input configuration and code formatting block
package acf_pkg;

    typedef enum logic [2:0] {
        ACF_MODE_SINGLE   = 3'h0,
        ACF_MODE_COM_UNI  = 3'h1,
        ACF_MODE_COM_BI   = 3'h2,
        ACF_MODE_PAIR_UNI = 3'h3,
        ACF_MODE_PAIR_BI  = 3'h4
    } acf_mode_type;

    typedef enum logic [1:0] {
        ACF_NEG_GND  = 2'h0,
        ACF_NEG_COM  = 2'h1,
        ACF_NEG_PAIR = 2'h2
    } acf_neg_type;

    typedef struct packed {
        logic [2:0]  pair_positive_input;
        logic [2:0]  pair_negative_input;
        acf_neg_type neg_ref;
    } acf_route_type;

    typedef struct packed {
        acf_mode_type  mode;
        acf_route_type route;
        logic          bipolar;
        logic          bandwidth_select;
        logic          reserved_code;
    } acf_sel_type;

endpackage

// ---- rtl/acf_mode_decode.sv ----
// Decode of the configuration word into input routing, range and filter setting
`timescale 1ns/1ps
`default_nettype none
`include "acf_cfg.svh"

module acf_mode_decode
    import acf_pkg::*;
(
    // Configuration in
    input  wire logic [`ACF_CFG_W-1:0] cfg_word,
    // Decoded selection out
    output acf_sel_type                sel
);

    logic [2:0] incc;
    logic [2:0] chan;
    logic       is_pair;
    logic       is_se;
    logic       is_rsvd;
    logic       is_bi;

    assign incc    = cfg_word[`ACF_INCC_HI:`ACF_INCC_LO];
    assign chan    = cfg_word[`ACF_CH_HI:`ACF_CH_LO];
    assign is_pair = ~incc[`ACF_PAIR_BIT];
    assign is_se   = (incc == `ACF_INCC_SE);
    // Undefined code falls back to the safe unipolar ground setting
    assign is_rsvd = (incc == `ACF_INCC_RSVD);
    assign is_bi   = ~incc[`ACF_UNI_BIT] & ~is_rsvd;

    always_comb begin
        sel.bandwidth_select = 1'b0;
        sel.reserved_code    = is_rsvd;
        sel.bipolar          = is_bi;
        sel.route.pair_positive_input = chan;
        // partner is the other input of the pair
        sel.route.pair_negative_input = chan ^ `ACF_CH_PAIR_MASK;
        if (is_pair) begin
            sel.mode          = is_bi ? ACF_MODE_PAIR_BI : ACF_MODE_PAIR_UNI;
            sel.route.neg_ref = ACF_NEG_PAIR;
        end else if (is_se || is_rsvd) begin
            sel.mode          = ACF_MODE_SINGLE;
            sel.route.neg_ref = ACF_NEG_GND;
        end else begin
            sel.mode          = is_bi ? ACF_MODE_COM_BI : ACF_MODE_COM_UNI;
            sel.route.neg_ref = ACF_NEG_COM;
        end
        sel.bandwidth_select = cfg_word[`ACF_BW_BIT];
    end

endmodule
`default_nettype wire

// ---- rtl/acf_code_format.sv ----
// Conversion of a raw difference into straight binary or twos complement, saturating except on bipolar underrange
`timescale 1ns/1ps
`default_nettype none
`include "acf_cfg.svh"

module acf_code_format (
    // Raw result and range
    input  wire logic signed [`ACF_DIFF_W-1:0] raw_diff,
    input  wire logic                          bipolar,
    // Formatted result
    output logic             [`ACF_CODE_W-1:0] code,
    output logic                               over_range,
    output logic                               under_range
);

    logic signed [`ACF_DIFF_W-1:0] top_in;
    logic signed [`ACF_DIFF_W-1:0] bot_in;
    logic        [`ACF_CODE_W-1:0] top_code;
    logic        [`ACF_CODE_W-1:0] under_code;

    assign top_in      = bipolar ? `ACF_BI_MAX   : `ACF_UNI_MAX;
    assign bot_in      = bipolar ? `ACF_BI_MIN   : `ACF_UNI_MIN;
    assign top_code    = bipolar ? `ACF_BI_TOP   : `ACF_UNI_TOP;
    // bipolar underrange gives the code one step below zero
    assign under_code  = bipolar ? `ACF_BI_UNDER : `ACF_UNI_BOT;
    assign over_range  = (raw_diff > top_in);
    assign under_range = (raw_diff < bot_in);

    // saturate to the top code of the active format
    // in range the low bits already hold the right format
    assign code = over_range  ? top_code :
                  under_range ? under_code :
                  raw_diff[`ACF_CODE_W-1:0];

endmodule
`default_nettype wire

// ---- rtl/acf_top.sv ----
// Input configuration and output code formatting for an 8-channel 16-bit converter
`timescale 1ns/1ps
`default_nettype none
`include "acf_cfg.svh"

module acf_top
    import acf_pkg::*;
#(
    parameter int unsigned CONV_CYCLES = (`ACF_CONV_NS + `ACF_CLK_NS - 1) / `ACF_CLK_NS
) (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          sys_rst,
    // Configuration load from the serial side
    input  wire logic                          cfg_load,
    input  wire logic [`ACF_CFG_W-1:0]         cfg_word,
    // Converter core
    input  wire logic                          conv_sample,
    input  wire logic                          sar_done,
    input  wire logic signed [`ACF_DIFF_W-1:0] sar_diff,
    // Routing and filter control
    output acf_sel_type                        active_sel_ff,
    output logic [`ACF_CFG_W-1:0]              cfg_word_ff,
    // Formatted result
    output logic [`ACF_CODE_W-1:0]             result_ff,
    output logic                               result_valid_ff,
    output logic                               result_bipolar_ff,
    output logic                               over_range_ff,
    output logic                               under_range_ff,
    // Start spacing check
    output logic                               rate_violation_ff
);

    localparam logic [`ACF_GAP_W-1:0] FULL_GAP    = `ACF_GAP_W'(CONV_CYCLES);
    localparam logic [`ACF_GAP_W-1:0] QUARTER_GAP = `ACF_GAP_W'(CONV_CYCLES * `ACF_BW_DIV);

    acf_sel_type                sel;
    logic                       samp_bipolar_ff;
    logic                       nxt_samp_bipolar;
    logic [`ACF_CFG_W-1:0]      nxt_cfg_word;
    logic [`ACF_CODE_W-1:0]     fmt_code;
    logic                       fmt_over;
    logic                       fmt_under;
    logic [`ACF_GAP_W-1:0]      gap_cnt_ff;
    logic [`ACF_GAP_W-1:0]      nxt_gap_cnt;
    logic [`ACF_GAP_W-1:0]      need_gap;
    logic                       gap_short;
    logic                       gap_at_max;

    // one configuration word holds every option
    assign nxt_cfg_word = cfg_load ? cfg_word : cfg_word_ff;

    acf_mode_decode u_decode (
        .cfg_word (cfg_word_ff),
        .sel      (sel)
    );

    // range is frozen at the sampling edge
    assign nxt_samp_bipolar = conv_sample ? sel.bipolar : samp_bipolar_ff;

    acf_code_format u_format (
        .raw_diff    (sar_diff),
        .bipolar     (samp_bipolar_ff),
        .code        (fmt_code),
        .over_range  (fmt_over),
        .under_range (fmt_under)
    );

    // Spacing counter saturates so a long idle never wraps into a false alarm
    assign gap_at_max  = (gap_cnt_ff == {`ACF_GAP_W{1'b1}});
    assign nxt_gap_cnt = conv_sample ? {{(`ACF_GAP_W-1){1'b0}}, 1'b1} :
                         gap_at_max  ? gap_cnt_ff :
                         gap_cnt_ff + {{(`ACF_GAP_W-1){1'b0}}, 1'b1};
    // quarter bandwidth needs four times the start spacing
    assign need_gap    = active_sel_ff.bandwidth_select ? QUARTER_GAP : FULL_GAP;
    assign gap_short   = conv_sample && (gap_cnt_ff < need_gap);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_word_ff <= `ACF_CFG_RST;
        end else begin
            cfg_word_ff <= nxt_cfg_word;
        end
    end

    // routing and filter setting follow the decoded word
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            active_sel_ff   <= '0;
            samp_bipolar_ff <= 1'b0;
        end else begin
            active_sel_ff   <= sel;
            samp_bipolar_ff <= nxt_samp_bipolar;
        end
    end

    // result register, format picked by the sampled range
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            result_ff         <= '0;
            result_valid_ff   <= 1'b0;
            result_bipolar_ff <= 1'b0;
            over_range_ff     <= 1'b0;
            under_range_ff    <= 1'b0;
        end else begin
            result_valid_ff <= sar_done;
            if (sar_done) begin
                result_ff         <= fmt_code;
                result_bipolar_ff <= samp_bipolar_ff;
                over_range_ff     <= fmt_over;
                under_range_ff    <= fmt_under;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            gap_cnt_ff        <= {`ACF_GAP_W{1'b1}};
            rate_violation_ff <= 1'b0;
        end else begin
            gap_cnt_ff        <= nxt_gap_cnt;
            rate_violation_ff <= gap_short;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    logic in_uni;
    logic in_bi;
    assign in_uni = (sar_diff >= `ACF_UNI_MIN) && (sar_diff <= `ACF_UNI_MAX);
    assign in_bi  = (sar_diff >= `ACF_BI_MIN) && (sar_diff <= `ACF_BI_MAX);

    chk_uni_straight: assert property (
        sar_done && !samp_bipolar_ff && in_uni
        |=> result_ff == $past(sar_diff[`ACF_CODE_W-1:0]) && !result_bipolar_ff
    ) else $error("unipolar result not straight binary");

    chk_bi_twos: assert property (
        sar_done && samp_bipolar_ff && in_bi
        |=> result_ff == $past(sar_diff[`ACF_CODE_W-1:0]) && result_bipolar_ff
    ) else $error("bipolar result not twos complement");

    chk_uni_midscale: assert property (
        sar_done && !samp_bipolar_ff && sar_diff == `ACF_UNI_MID_IN
        |=> result_ff == `ACF_UNI_MID
    ) else $error("unipolar midscale code wrong");

    chk_bi_bottom: assert property (
        sar_done && samp_bipolar_ff && sar_diff == `ACF_BI_MIN
        |=> result_ff == `ACF_BI_BOT && !under_range_ff
    ) else $error("bipolar most negative code wrong");

    chk_over_saturate: assert property (
        sar_done && (samp_bipolar_ff ? sar_diff > `ACF_BI_MAX : sar_diff > `ACF_UNI_MAX)
        |=> over_range_ff
            && result_ff == (result_bipolar_ff ? `ACF_BI_TOP : `ACF_UNI_TOP)
    ) else $error("overrange not saturated to top code");

    chk_bi_under: assert property (
        sar_done && samp_bipolar_ff && sar_diff < `ACF_BI_MIN
        |=> under_range_ff && result_ff == `ACF_BI_UNDER
    ) else $error("bipolar underrange code wrong");

    chk_bw_follow: assert property (
        cfg_load ##1 !cfg_load
        |=> active_sel_ff.bandwidth_select == $past(cfg_word[`ACF_BW_BIT], 2)
    ) else $error("bandwidth select does not follow configuration");

    chk_rate_flag: assert property (
        conv_sample && active_sel_ff.bandwidth_select
        ##1 !conv_sample [*8] ##1 conv_sample
        |=> rate_violation_ff
    ) else $error("fast start under quarter bandwidth not flagged");

    chk_single_ended: assert property (
        active_sel_ff.mode == ACF_MODE_SINGLE
        |-> !active_sel_ff.bipolar && active_sel_ff.route.neg_ref == ACF_NEG_GND
    ) else $error("single-ended mode routed or ranged wrongly");

    chk_common_mode: assert property (
        cfg_load && cfg_word[`ACF_INCC_HI:`ACF_INCC_LO] inside {`ACF_INCC_COM_BI,
                                                             `ACF_INCC_COM_UNI}
        ##2 !$past(cfg_load)
        |-> active_sel_ff.route.neg_ref == ACF_NEG_COM
            && active_sel_ff.bipolar == !$past(cfg_word[`ACF_INCC_HI], 2)
    ) else $error("common input mode decoded wrongly");

    chk_pair_mode: assert property (
        cfg_load && !cfg_word[`ACF_INCC_LO+1] ##1 !cfg_load
        |=> active_sel_ff.route.neg_ref == ACF_NEG_PAIR
            && active_sel_ff.bipolar == !$past(cfg_word[`ACF_INCC_HI], 2)
    ) else $error("paired mode decoded wrongly");

    chk_pair_member: assert property (
        active_sel_ff.route.neg_ref == ACF_NEG_PAIR
        |-> (active_sel_ff.route.pair_positive_input
             ^ active_sel_ff.route.pair_negative_input) == `ACF_CH_PAIR_MASK
            && active_sel_ff.route.pair_positive_input
               == $past(cfg_word_ff[`ACF_CH_HI:`ACF_CH_LO])
    ) else $error("pair members wrong");

    chk_sample_range: assert property (
        conv_sample ##1 (!conv_sample && !cfg_load) [*3]
        |-> samp_bipolar_ff == $past(sel.bipolar, 3)
    ) else $error("range not held from sampling edge");

    // Configuration word checks
    chk_cfg_load: assert property (
        cfg_load |=> cfg_word_ff == $past(cfg_word)
    ) else $error("configuration word not loaded");

    chk_cfg_hold: assert property (
        !cfg_load |=> $stable(cfg_word_ff)
    ) else $error("configuration word changed without a load");

    chk_bw_decode: assert property (
        !$past(sys_rst)
        |-> active_sel_ff.bandwidth_select == $past(cfg_word_ff[`ACF_BW_BIT])
    ) else $error("bandwidth select differs from stored word");

    // Undefined field code must land on the safe setting
    chk_reserved_safe: assert property (
        active_sel_ff.reserved_code
        |-> active_sel_ff.mode == ACF_MODE_SINGLE && !active_sel_ff.bipolar
    ) else $error("undefined field code not mapped to single-ended");

    chk_pair_only: assert property (
        active_sel_ff.route.neg_ref == ACF_NEG_PAIR
        |-> active_sel_ff.mode inside {ACF_MODE_PAIR_UNI, ACF_MODE_PAIR_BI}
    ) else $error("pair routing outside a paired mode");

    // Result checks
    chk_uni_top: assert property (
        sar_done && !samp_bipolar_ff && sar_diff == `ACF_UNI_MAX
        |=> result_ff == `ACF_UNI_TOP && !over_range_ff
    ) else $error("unipolar top code wrong");

    chk_bi_top: assert property (
        sar_done && samp_bipolar_ff && sar_diff == `ACF_BI_MAX
        |=> result_ff == `ACF_BI_TOP && !over_range_ff
    ) else $error("bipolar top code wrong");

    chk_bi_zero: assert property (
        sar_done && samp_bipolar_ff && sar_diff == `ACF_ZERO_IN
        |=> result_ff == `ACF_BI_ZERO
    ) else $error("bipolar zero code wrong");

    chk_uni_under: assert property (
        sar_done && !samp_bipolar_ff && sar_diff < `ACF_UNI_MIN
        |=> under_range_ff && result_ff == `ACF_UNI_BOT
    ) else $error("unipolar underrange code wrong");

    chk_bi_inrange: assert property (
        sar_done && samp_bipolar_ff && in_bi
        |=> !over_range_ff && !under_range_ff
    ) else $error("bipolar in-range result flagged");

    chk_flags_excl: assert property (
        !(over_range_ff && under_range_ff)
    ) else $error("overrange and underrange both set");

    chk_valid_pulse: assert property (
        sar_done |=> result_valid_ff
    ) else $error("result valid missing");

    chk_valid_low: assert property (
        !sar_done |=> !result_valid_ff
    ) else $error("result valid without a result");

    chk_result_hold: assert property (
        !sar_done
        |=> $stable(result_ff) && $stable(result_bipolar_ff)
    ) else $error("result changed without a new conversion");

    chk_sample_capture: assert property (
        conv_sample |=> samp_bipolar_ff == $past(sel.bipolar)
    ) else $error("range not captured at sampling edge");

    cov_bi_result:   cover property (sar_done && samp_bipolar_ff ##1 result_valid_ff);
    cov_uni_over:    cover property (sar_done && !samp_bipolar_ff && sar_diff > `ACF_UNI_MAX);
    cov_mode_switch: cover property (conv_sample ##1 cfg_load ##[1:20] sar_done);
    cov_rate_viol:   cover property (rate_violation_ff);
    cov_pair_bi:     cover property (active_sel_ff.route.neg_ref == ACF_NEG_PAIR && active_sel_ff.bipolar);

endmodule
`default_nettype wire

// ---- tb/acf_host_model.sv ----
// Host controller model: loads the configuration word and paces conversion starts
`timescale 1ns/1ps
`default_nettype none
`include "acf_cfg.svh"

module acf_host_model #(
    parameter int unsigned CONV_CYCLES = 4
) (
    // Clock
    input  wire logic                  clk_sys,
    // Host side requests
    output logic                       cfg_load,
    output logic [`ACF_CFG_W-1:0]      cfg_word,
    output logic                       conv_sample,
    // Observed flag
    input  wire logic                  rate_violation_ff
);
    logic quarter;

    initial begin
        cfg_load    = 1'b0;
        cfg_word    = '0;
        conv_sample = 1'b0;
        quarter     = 1'b0;
    end

    // whole word in a single load
    task automatic load_cfg(input logic [`ACF_CFG_W-1:0] w);
        @(posedge clk_sys);
        cfg_load <= 1'b1;
        cfg_word <= w;
        quarter = w[`ACF_BW_BIT];
        @(posedge clk_sys);
        cfg_load <= 1'b0;
        // Released word shows junk, not the last value
        cfg_word <= ~w;
        repeat (3) @(posedge clk_sys);
    endtask

    // start spacing follows the bandwidth; short trims that many cycles on purpose
    task automatic start_conv(input int short, output logic viol);
        int need;
        need = quarter ? 4 * CONV_CYCLES : CONV_CYCLES;
        @(posedge clk_sys);
        conv_sample <= 1'b1;
        @(posedge clk_sys);
        conv_sample <= 1'b0;
        #1;
        viol = rate_violation_ff;
        repeat (need - 2 - short) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ---- tb/test_adc_input_config_and_code_format.sv ----
// Self-checking bench for input decode and result code formatting
`timescale 1ns/1ps
`default_nettype none

module test_adc_input_config_and_code_format;
    import acf_pkg::*;
    localparam int unsigned CONV = 4;
    logic               clk_sys = 1'b0;
    logic               sys_rst = 1'b1;
    logic               sar_done = 1'b0;
    logic signed [17:0] sar_diff = '0;
    logic               cfg_load;
    logic [13:0]        cfg_word;
    logic               conv_sample;
    acf_sel_type        active_sel_ff;
    logic [13:0]        cfg_word_ff;
    logic [15:0]        result_ff;
    logic               result_valid_ff;
    logic               result_bipolar_ff;
    logic               over_range_ff;
    logic               under_range_ff;
    logic               rate_violation_ff;
    int                 bad_count = 0;
    int                 n_compared = 0;
    int                 cycles = 0;
    int                 q[$];
    logic               v;

    acf_top #(.CONV_CYCLES(CONV)) i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_load(cfg_load), .cfg_word(cfg_word),
        .conv_sample(conv_sample), .sar_done(sar_done), .sar_diff(sar_diff),
        .active_sel_ff(active_sel_ff), .cfg_word_ff(cfg_word_ff), .result_ff(result_ff),
        .result_valid_ff(result_valid_ff), .result_bipolar_ff(result_bipolar_ff),
        .over_range_ff(over_range_ff), .under_range_ff(under_range_ff),
        .rate_violation_ff(rate_violation_ff));

    acf_host_model #(.CONV_CYCLES(CONV)) i_host (
        .clk_sys(clk_sys), .cfg_load(cfg_load), .cfg_word(cfg_word),
        .conv_sample(conv_sample), .rate_violation_ff(rate_violation_ff));

    always #12.5 clk_sys = ~clk_sys;

    task automatic conclude();
        $display("counts: compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Long enough for all tests with wide margin
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic fmt(input int d, input bit bi, output logic [15:0] c,
                       output logic ov, output logic un);
        ov = 1'b0;
        un = 1'b0;
        c  = d[15:0];
        if (bi && d > 32767) begin
            c  = 16'h7fff;
            ov = 1'b1;
        end else if (bi && d < -32768) begin
            c  = 16'hffff;
            un = 1'b1;
        end else if (!bi && d > 65535) begin
            c  = 16'hffff;
            ov = 1'b1;
        end else if (!bi && d < 0) begin
            c  = 16'h0000;
            un = 1'b1;
        end
    endtask

    task automatic res(input int d, input bit bi);
        logic [15:0] c;
        logic        ov;
        logic        un;
        fmt(d, bi, c, ov, un);
        @(posedge clk_sys);
        sar_done <= 1'b1;
        sar_diff <= d[17:0];
        @(posedge clk_sys);
        sar_done <= 1'b0;
        #1;
        chk(result_valid_ff, 1);
        chk(result_ff, c);
        chk(over_range_ff, ov);
        chk(under_range_ff, un);
        chk(result_bipolar_ff, bi);
    endtask

    task automatic dec(input logic [2:0] f, input logic [2:0] ch, input logic bw);
        logic [13:0]  w;
        acf_mode_type m;
        acf_neg_type  n;
        w = 14'($urandom);
        w[12:10] = f;
        w[9:7] = ch;
        w[6] = bw;
        case (f)
            3'h6:       m = ACF_MODE_COM_UNI;
            3'h2:       m = ACF_MODE_COM_BI;
            3'h0, 3'h1: m = ACF_MODE_PAIR_BI;
            3'h4, 3'h5: m = ACF_MODE_PAIR_UNI;
            default:    m = ACF_MODE_SINGLE;
        endcase
        n = !f[1] ? ACF_NEG_PAIR : (f == 3'h2 || f == 3'h6) ? ACF_NEG_COM : ACF_NEG_GND;
        i_host.load_cfg(w);
        #1;
        chk(cfg_word_ff, w);
        chk(active_sel_ff.mode, m);
        chk(active_sel_ff.route.neg_ref, n);
        chk(active_sel_ff.bipolar, (f == 3'h2 || f[2:1] == 2'b00));
        chk(active_sel_ff.bandwidth_select, bw);
        chk(active_sel_ff.reserved_code, f == 3'h3);
        if (!f[1]) begin
            chk(active_sel_ff.route.pair_positive_input, ch);
            chk(active_sel_ff.route.pair_negative_input, ch ^ 3'h1);
        end
    endtask

    initial begin
        void'($urandom(80));
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        for (int f = 0; f < 8; f++) dec(f[2:0], 3'($urandom), 1'($urandom));
        dec(3'h0, 3'h0, 1'b0);
        dec(3'h5, 3'h1, 1'b1);
        $display("test decode done");
        q = {0, 1, 32767, 32768, 65535, 65536, -1, -32768, -32769, 131071, -131072};
        repeat (6) q.push_back(int'($urandom_range(262143, 0)) - 131072);
        for (int b = 0; b < 2; b++) begin
            i_host.load_cfg(b ? 14'h0800 : 14'h1c00);
            i_host.start_conv(0, v);
            foreach (q[i]) res(q[i], b[0]);
        end
        $display("test format done");
        // Range comes from the sampling moment, not the later load
        i_host.load_cfg(14'h0800);
        i_host.start_conv(0, v);
        i_host.load_cfg(14'h1c00);
        res(-1, 1'b1);
        $display("test sample range done");
        for (int b = 0; b < 2; b++) begin
            i_host.load_cfg(b ? 14'h1c40 : 14'h1c00);
            i_host.start_conv(0, v);
            i_host.start_conv(0, v);
            chk(v, 0);
            i_host.start_conv(1, v);
            chk(v, 0);
            i_host.start_conv(0, v);
            chk(v, 1);
        end
        i_host.start_conv(7, v);
        i_host.start_conv(0, v);
        chk(v, 1);
        $display("test rate done");
        conclude();
    end
endmodule
`default_nettype wire
